/* src/rfc_flow_ctrl.sv */
// serial host port, byte buffer flow control and transmit/receive hand-off
`timescale 1ns/1ps
// Function
// - reset-buffer command empties buffer and clears both pointers and counters
// - buffer locations are filled cyclically, wrapping after the last
// - bytes written at address 1f go into locations 0 to 23
// - input counter counts every byte loaded into the buffer
// - output counter counts every byte taken out of the buffer
// - input and output counters are twelve bits wide
// - interrupt request when buffer holds fewer than six bytes during transmission, while input count is below transmit length
// - interrupt request when buffer holds more than eighteen bytes during reception
// - bytes handed to transmitter never exceed programmed transmit length
// - transmitter is told when the final byte is handed over
// - status register reports current byte count
// - overflow flag set when buffer overflows
// - low-level flag set when level is low during transmission, while input count is below transmit length
// - high-level flag set when level is high during reception
module rfc_flow_ctrl (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic spi_en_n_in,
  input wire logic spi_clk_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  input wire logic [rfc_pkg::DATA_W-1:0] rx_data_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  input wire logic rx_active_in,
  output logic [rfc_pkg::DATA_W-1:0] tx_data_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic tx_last_out,
  output logic tx_active_out,
  output logic fifo_irq_out
);
  import rfc_pkg::*;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic clk_d;
    logic sdi_d;
    rfc_sp_state_t sp;
    logic [2:0] bits;
    logic [7:0] in_sh;
    logic [7:0] out_sh;
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic cont;
    logic sdo;
    logic sdo_oe;
    logic hw_pend;
    logic [7:0] hw_data;
    logic [CNT_W-1:0] in_cnt;
    logic [CNT_W-1:0] out_cnt;
    logic [CNT_W-1:0] sent;
    logic [CNT_W-1:0] tx_len;
    logic tx_active;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_last;
    logic rx_ready;
    logic fove;
    logic flol;
    logic fhil;
    logic low_d;
    logic high_d;
    logic irq;
  } rfc_state_t;

  rfc_state_t s_r;
  rfc_state_t s_nxt;

  logic en_act;
  logic rise;
  logic fall;
  logic [7:0] byte_v;
  logic [7:0] rv;
  logic fifo_clear;
  logic tx_start;
  logic host_pop;
  logic rx_take;
  logic ovf_set;
  logic fifo_wr_valid;
  logic fifo_wr_ready;
  logic [7:0] fifo_wr_data;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [7:0] fifo_rd_data;
  logic [LVL_W-1:0] fifo_level;
  logic push_ok;
  logic pop_ok;
  logic tx_load;
  logic [CNT_W-1:0] diff;
  logic [CNT_W-1:0] diff_nxt;
  logic [LVL_W-1:0] lvl;
  logic low_c;
  logic high_c;

  rfc_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .clear_in(fifo_clear),
    .wr_valid_in(fifo_wr_valid),
    .wr_ready_out(fifo_wr_ready),
    .wr_data_in(fifo_wr_data),
    .rd_valid_out(fifo_rd_valid),
    .rd_ready_in(fifo_rd_ready),
    .rd_data_out(fifo_rd_data),
    .level_out(fifo_level)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = {spi_sdi_in, spi_clk_in, spi_en_n_in};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.clk_d = s_r.sync2[SYNC_CLK];
    s_nxt.sdi_d = s_r.sync2[SYNC_SDI];
    en_act = !s_r.sync2[SYNC_EN];
    rise = en_act && !s_r.clk_d && s_r.sync2[SYNC_CLK];
    fall = en_act && s_r.clk_d && !s_r.sync2[SYNC_CLK];
    // sdi is taken one sample before the falling edge, clear of its short hold window
    byte_v = {s_r.in_sh[6:0], s_r.sdi_d};
    diff = s_r.in_cnt - s_r.out_cnt;
    lvl = diff[LVL_W-1:0];
    fifo_clear = 1'b0;
    tx_start = 1'b0;
    host_pop = 1'b0;
    ovf_set = 1'b0;
    rv = 8'h00;
    case (s_r.addr)
      ADDR_STATUS: begin
        rv[LVL_W-1:0] = lvl;
        rv[ST_FOVE_BIT] = s_r.fove;
        rv[ST_FHIL_BIT] = s_r.fhil;
        rv[ST_FLOL_BIT] = s_r.flol;
      end
      ADDR_TXLEN_HI: rv = {4'h0, s_r.tx_len[11:8]};
      ADDR_TXLEN_LO: rv = s_r.tx_len[7:0];
      ADDR_FIFO: rv = fifo_rd_valid ? fifo_rd_data : 8'h00;
      default: rv = 8'h00;
    endcase

    // host byte waits one cycle so it never competes with a receiver push
    rx_take = rx_valid_in && s_r.rx_ready;
    fifo_wr_valid = rx_take || s_r.hw_pend;
    fifo_wr_data = rx_take ? rx_data_in : s_r.hw_data;
    if (!rx_take && s_r.hw_pend) begin
      s_nxt.hw_pend = 1'b0;
      ovf_set = !fifo_wr_ready;
    end

    if (!en_act) begin
      s_nxt.sp = RFC_SP_HDR;
      s_nxt.bits = 3'h0;
      s_nxt.rd = 1'b0;
    end else begin
      if (rise && s_r.sp == RFC_SP_DATA && s_r.rd) begin
        if (s_r.bits == 3'h0) begin
          // fetch lazily at the first bit so no byte is popped that the host never clocks
          host_pop = (s_r.addr == ADDR_FIFO) && fifo_rd_valid;
          s_nxt.sdo = rv[7];
          s_nxt.out_sh = {rv[6:0], 1'b0};
        end else begin
          s_nxt.sdo = s_r.out_sh[7];
          s_nxt.out_sh = {s_r.out_sh[6:0], 1'b0};
        end
      end
      if (fall) begin
        s_nxt.in_sh = byte_v;
        s_nxt.bits = s_r.bits + 3'h1;
        if (s_r.bits == BITS_LAST) begin
          case (s_r.sp)
            RFC_SP_HDR: begin
              if (byte_v[HDR_CMD_BIT]) begin
                fifo_clear = (byte_v[4:0] == CMD_RESET_FIFO);
                tx_start = (byte_v[4:0] == CMD_TRANSMIT);
              end else begin
                s_nxt.addr = byte_v[4:0];
                s_nxt.rd = byte_v[HDR_READ_BIT];
                s_nxt.cont = byte_v[HDR_CONT_BIT];
                s_nxt.sp = RFC_SP_DATA;
              end
            end
            RFC_SP_DATA: begin
              if (!s_r.rd) begin
                case (s_r.addr)
                  ADDR_TXLEN_HI: s_nxt.tx_len[11:8] = byte_v[3:0];
                  ADDR_TXLEN_LO: s_nxt.tx_len[7:0] = byte_v;
                  ADDR_FIFO: begin
                    s_nxt.hw_pend = 1'b1;
                    s_nxt.hw_data = byte_v;
                  end
                  default: s_nxt.hw_pend = s_nxt.hw_pend;
                endcase
              end
              if (s_r.cont) begin
                // the buffer address does not advance: repeated bytes stream through it
                if (s_r.addr != ADDR_FIFO) begin
                  s_nxt.addr = s_r.addr + 5'h01;
                end
              end else begin
                s_nxt.sp = RFC_SP_HDR;
              end
            end
            default: s_nxt.sp = RFC_SP_HDR;
          endcase
        end
      end
    end
    s_nxt.sdo_oe = en_act && s_nxt.sp == RFC_SP_DATA && s_nxt.rd;

    tx_load = s_r.tx_active && (s_r.sent < s_r.tx_len) && fifo_rd_valid &&
              (!s_r.tx_valid || tx_ready_in) && !host_pop && !fifo_clear;
    fifo_rd_ready = host_pop || tx_load;
    push_ok = fifo_wr_valid && fifo_wr_ready && !fifo_clear;
    pop_ok = fifo_rd_ready && fifo_rd_valid && !fifo_clear;

    if (s_r.tx_valid && tx_ready_in) begin
      s_nxt.tx_valid = 1'b0;
      s_nxt.tx_last = 1'b0;
    end
    if (tx_load) begin
      s_nxt.tx_data = fifo_rd_data;
      s_nxt.tx_valid = 1'b1;
      s_nxt.sent = s_r.sent + 12'h001;
      s_nxt.tx_last = (s_r.sent + 12'h001 == s_r.tx_len);
      if (s_r.sent + 12'h001 == s_r.tx_len) begin
        s_nxt.tx_active = 1'b0;
      end
    end
    if (tx_start) begin
      s_nxt.tx_active = (s_r.tx_len != CNT_RST);
      s_nxt.sent = CNT_RST;
    end

    if (fifo_clear) begin
      s_nxt.in_cnt = CNT_RST;
      s_nxt.out_cnt = CNT_RST;
    end else begin
      if (push_ok) begin
        s_nxt.in_cnt = s_r.in_cnt + 12'h001;
      end
      if (pop_ok) begin
        s_nxt.out_cnt = s_r.out_cnt + 12'h001;
      end
    end
    diff_nxt = s_nxt.in_cnt - s_nxt.out_cnt;
    s_nxt.rx_ready = !s_nxt.hw_pend && (diff_nxt < FIFO_DEPTH_CNT);

    // low only counts while more transmit data is still due, so the drain at the end is quiet
    low_c = s_r.tx_active && (lvl < LOW_LEVEL) && (s_r.in_cnt < s_r.tx_len);
    high_c = rx_active_in && (lvl > HIGH_LEVEL);
    // a set in the clearing cycle wins over the clear
    s_nxt.fove = (fifo_clear ? 1'b0 : s_r.fove) | ovf_set;
    s_nxt.flol = (fifo_clear ? 1'b0 : s_r.flol) | low_c;
    s_nxt.fhil = (fifo_clear ? 1'b0 : s_r.fhil) | high_c;
    s_nxt.low_d = low_c;
    s_nxt.high_d = high_c;
    s_nxt.irq = (low_c && !s_r.low_d) || (high_c && !s_r.high_d);
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r <= '0;
      s_r.sync1 <= SYNC_RST;
      s_r.sync2 <= SYNC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign spi_sdo_out = s_r.sdo;
  assign spi_sdo_oe_out = s_r.sdo_oe;
  assign rx_ready_out = s_r.rx_ready;
  assign tx_data_out = s_r.tx_data;
  assign tx_valid_out = s_r.tx_valid;
  assign tx_last_out = s_r.tx_last;
  assign tx_active_out = s_r.tx_active;
  assign fifo_irq_out = s_r.irq;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  property p_level_match;
    fifo_level == lvl;
  endproperty
  a_level_match: assert property (p_level_match) else $error("count differs from buffer");

  property p_clear;
    fifo_clear |=> (s_r.in_cnt == CNT_RST) && (s_r.out_cnt == CNT_RST) && (fifo_level == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("reset command left data");

  property p_in_cnt;
    (push_ok && !fifo_clear) |=> s_r.in_cnt == $past(s_r.in_cnt) + 12'h001;
  endproperty
  a_in_cnt: assert property (p_in_cnt) else $error("input counter missed a byte");

  property p_out_cnt;
    (!pop_ok && !fifo_clear) |=> $stable(s_r.out_cnt);
  endproperty
  a_out_cnt: assert property (p_out_cnt) else $error("output counter moved idle");

  property p_tx_len;
    s_r.tx_valid |-> s_r.sent <= s_r.tx_len;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("sent beyond transmit length");

  property p_last;
    $rose(s_r.tx_last) |-> s_r.tx_valid && (s_r.sent == s_r.tx_len) && !s_r.tx_active;
  endproperty
  a_last: assert property (p_last) else $error("last marker misplaced");

  property p_fove;
    ovf_set |=> s_r.fove [*2];
  endproperty
  a_fove: assert property (p_fove) else $error("overflow flag not held");

  property p_low_irq;
    (low_c && !s_r.low_d) |=> s_r.irq && s_r.flol;
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("low level not signalled");

  property p_high_irq;
    (high_c && !s_r.high_d) |=> s_r.irq ##1 s_r.fhil;
  endproperty
  a_high_irq: assert property (p_high_irq) else $error("high level not signalled");

  property p_no_overfill;
    s_r.rx_ready |-> fifo_level < LVL_W'(FIFO_DEPTH);
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("ready while buffer full");
endmodule

/* src/rfc_pkg.sv */
// shared constants and types of the reader fifo flow control block
package rfc_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 24;
  localparam int CNT_W = 12;
  localparam int LVL_W = 5;
  localparam int ADDR_W = 5;
  localparam logic [11:0] FIFO_DEPTH_CNT = 12'h018;
  localparam logic [4:0] ADDR_STATUS = 5'h1c;
  localparam logic [4:0] ADDR_TXLEN_HI = 5'h1d;
  localparam logic [4:0] ADDR_TXLEN_LO = 5'h1e;
  localparam logic [4:0] ADDR_FIFO = 5'h1f;
  localparam logic [4:0] CMD_RESET_FIFO = 5'h0f;
  localparam logic [4:0] CMD_TRANSMIT = 5'h10;
  localparam int HDR_CMD_BIT = 7;
  localparam int HDR_READ_BIT = 6;
  localparam int HDR_CONT_BIT = 5;
  localparam int ST_FOVE_BIT = 7;
  localparam int ST_FHIL_BIT = 6;
  localparam int ST_FLOL_BIT = 5;
  localparam logic [4:0] LOW_LEVEL = 5'h06;
  localparam logic [4:0] HIGH_LEVEL = 5'h12;
  localparam logic [11:0] CNT_RST = 12'h000;
  localparam logic [2:0] SYNC_RST = 3'h1;
  localparam logic [2:0] BITS_LAST = 3'h7;
  localparam int SYNC_EN = 0;
  localparam int SYNC_CLK = 1;
  localparam int SYNC_SDI = 2;
  typedef enum logic [0:0] {
    RFC_SP_HDR = 1'b0,
    RFC_SP_DATA = 1'b1
  } rfc_sp_state_t;
endpackage

/* src/rfc_fifo.sv */
// cyclic byte buffer with clear, valid/ready on both sides
`timescale 1ns/1ps
module rfc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic clear_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [W-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [W-1:0] rd_data_out,
  output logic [$clog2(DEPTH+1)-1:0] level_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH-1);
  localparam logic [LW-1:0] LVL_FULL = LW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [LW-1:0] lvl;
  } rfc_fifo_st_t;

  rfc_fifo_st_t s_r;
  rfc_fifo_st_t s_nxt;
  logic push;
  logic pop;

  assign wr_ready_out = s_r.lvl < LVL_FULL;
  assign rd_valid_out = s_r.lvl != '0;
  assign rd_data_out = s_r.mem[s_r.rp];
  assign level_out = s_r.lvl;

  always_comb begin
    s_nxt = s_r;
    push = wr_valid_in && wr_ready_out;
    pop = rd_ready_in && rd_valid_out;
    if (clear_in) begin
      s_nxt = '0;
    end else begin
      if (push) begin
        s_nxt.mem[s_r.wp] = wr_data_in;
        s_nxt.wp = (s_r.wp == PTR_LAST) ? '0 : s_r.wp + PW'(1);
      end
      if (pop) begin
        s_nxt.rp = (s_r.rp == PTR_LAST) ? '0 : s_r.rp + PW'(1);
      end
      s_nxt.lvl = s_r.lvl + LW'(push) - LW'(pop);
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

/* verification/rfc_host_model.sv */
// host model that drives the device's serial port, bytes MSB first
`timescale 1ns/1ps
module rfc_host_model (
  input wire logic clk_sys_in,
  output logic spi_en_n_out,
  output logic spi_clk_out,
  output logic spi_sdi_out,
  input wire logic spi_sdo_in
);
  initial begin
    spi_en_n_out = 1'b1;
    spi_clk_out = 1'b0;
    spi_sdi_out = 1'b0;
  end
  // half of the 80 ns serial period, moved on the falling system edge
  task automatic half();
    repeat (4) @(negedge clk_sys_in);
  endtask
  // the serial clock stands low outside frames
  task automatic start();
    @(negedge clk_sys_in);
    spi_en_n_out = 1'b0;
    half();
  endtask
  task automatic stop();
    half();
    spi_en_n_out = 1'b1;
    // a released data line must not keep showing its last bit
    spi_sdi_out = ~spi_sdi_out;
    half();
  endtask
  // read bit taken just before the next rise, where sdo has long settled
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_clk_out = 1'b1;
      spi_sdi_out = tx[i];
      half();
      spi_clk_out = 1'b0;
      half();
      rx[i] = spi_sdo_in;
    end
  endtask
endmodule

/* verification/tb.sv */
// self-checking bench of the flow control block, host side through the serial port
`timescale 1ns/1ps
module tb;
  import rfc_pkg::*;
  logic clk_sys_in;
  logic nrst_in;
  logic spi_en_n, spi_clk, spi_sdi, sdo, sdo_oe;
  logic [7:0] rx_data, tx_data;
  logic rx_valid, rx_ready, rx_active, tx_valid, tx_ready, tx_last, tx_active, irq;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int irq_n = 0;
  rfc_host_model host (.clk_sys_in(clk_sys_in), .spi_en_n_out(spi_en_n),
    .spi_clk_out(spi_clk), .spi_sdi_out(spi_sdi), .spi_sdo_in(sdo));
  rfc_flow_ctrl dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .spi_en_n_in(spi_en_n),
    .spi_clk_in(spi_clk), .spi_sdi_in(spi_sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe),
    .rx_data_in(rx_data), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready),
    .rx_active_in(rx_active), .tx_data_out(tx_data), .tx_valid_out(tx_valid),
    .tx_ready_in(tx_ready), .tx_last_out(tx_last), .tx_active_out(tx_active),
    .fifo_irq_out(irq));
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // about 10000 cycles are needed; the ceiling leaves ample room
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_n <= irq_n + 1;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic frame(input logic [7:0] b[$]);
    logic [7:0] x;
    host.start();
    foreach (b[i]) host.xfer(b[i], x);
    host.stop();
  endtask
  task automatic wr_fifo(input int n, input logic [7:0] base);
    logic [7:0] x;
    host.start();
    host.xfer(8'h3f, x);
    for (int i = 0; i < n; i++) host.xfer(base + 8'(i), x);
    host.stop();
  endtask
  task automatic rd_fifo(input int n, input logic [7:0] base);
    logic [7:0] x;
    host.start();
    host.xfer(8'h7f, x);
    for (int i = 0; i < n; i++) begin
      host.xfer(8'h00, x);
      chk("buffer byte", base + 8'(i), x);
    end
    host.stop();
  endtask
  task automatic status(input logic [7:0] exp);
    logic [7:0] x;
    host.start();
    host.xfer(8'h5c, x);
    chk("sdo enable in read", 8'h01, {7'h0, sdo_oe});
    host.xfer(8'h00, x);
    host.stop();
    chk("status", exp, x);
    chk("sdo enable after frame", 8'h00, {7'h0, sdo_oe});
  endtask
  task automatic t_reset();
    chk("rx ready in reset", 8'h00, {7'h0, rx_ready});
    chk("tx valid in reset", 8'h00, {7'h0, tx_valid});
    chk("irq in reset", 8'h00, {7'h0, irq});
  endtask
  // pointers are moved off zero first so the overfilled load wraps mid-buffer
  task automatic t_overflow();
    logic [7:0] x;
    frame('{8'h8f});
    wr_fifo(20, 8'h80);
    rd_fifo(20, 8'h80);
    wr_fifo(25, 8'h10);
    status(8'h98);
    rd_fifo(24, 8'h10);
    status(8'h80);
    host.start();
    host.xfer(8'h01, x);
    host.xfer(8'h55, x);
    host.xfer(8'h41, x);
    host.xfer(8'h00, x);
    host.stop();
    chk("unmapped read", 8'h00, x);
    frame('{8'h8f});
    status(8'h00);
  endtask
  // the 25th byte is held offered for 50 cycles against a full buffer
  task automatic t_rx();
    int k;
    int irq0;
    frame('{8'h8f});
    irq0 = irq_n;
    rx_active = 1'b1;
    for (int i = 0; i < 25; i++) begin
      rx_valid = 1'b1;
      rx_data = 8'h40 + 8'(i);
      k = 0;
      while (rx_ready !== 1'b1 && k < 50) begin
        @(negedge clk_sys_in);
        k++;
      end
      if (i < 24) @(negedge clk_sys_in);
    end
    chk("rx ready when full", 8'h00, {7'h0, rx_ready});
    rx_valid = 1'b0;
    rx_active = 1'b0;
    chk("rx irq", 8'h01, {7'h0, irq_n > irq0});
    status(8'h58);
    rd_fifo(24, 8'h40);
    status(8'h40);
  endtask
  // transmitter stalls while the host loads five bytes against a length of three
  task automatic t_tx();
    int n;
    int irq0;
    logic [7:0] x;
    frame('{8'h8f, 8'h3d, 8'h00, 8'h03});
    irq0 = irq_n;
    frame('{8'h90, 8'h3f, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4});
    chk("tx irq", 8'h01, {7'h0, irq_n > irq0});
    chk("tx held valid", 8'h01, {7'h0, tx_valid});
    chk("tx held data", 8'ha0, tx_data);
    chk("tx active", 8'h01, {7'h0, tx_active});
    n = 0;
    tx_ready = 1'b1;
    for (int c = 0; c < 40; c++) begin
      if (tx_valid === 1'b1) begin
        chk("tx byte", 8'ha0 + 8'(n), tx_data);
        chk("tx last", {7'h0, n == 2}, {7'h0, tx_last});
        n++;
      end
      @(negedge clk_sys_in);
    end
    chk("tx count", 8'h03, 8'(n));
    chk("tx active after", 8'h00, {7'h0, tx_active});
    status(8'h22);
    // the length registers read back in one continuous access starting at the high register
    host.start();
    host.xfer(8'h7d, x);
    host.xfer(8'h00, x);
    chk("tx length high", 8'h00, x);
    host.xfer(8'h00, x);
    chk("tx length low", 8'h03, x);
    host.stop();
  endtask
  initial begin
    nrst_in = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_active = 1'b0;
    tx_ready = 1'b0;
    repeat (19) @(negedge clk_sys_in);
    t_reset();
    @(negedge clk_sys_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    status(8'h00);
    t_overflow();
    t_rx();
    t_tx();
    results();
  end
endmodule
